// ---- design/ar_params.svh ----
// constants for the auto-reclose sequencer: offsets, fields, reset values, timing
`ifndef AR_PARAMS_SVH
`define AR_PARAMS_SVH
`define AR_CLK_HZ 50000000
`define AR_TICK_MS 1
`define AR_TICK_CYC (`AR_CLK_HZ / 1000 * `AR_TICK_MS)
`define AR_NSHOT 5
`define AR_NSYNC 14
`define AR_NEV 16
`define AR_OFF_CTRL 8'h00
`define AR_OFF_STATUS 8'h04
`define AR_OFF_EVMASK 8'h08
`define AR_OFF_START 8'h0C
`define AR_OFF_GENRC 8'h10
`define AR_OFF_STAMP 8'h14
`define AR_OFF_SHOT 8'h20
`define AR_SHOT_STRIDE 8'h10
`define AR_SUB_DEAD 8'h00
`define AR_SUB_RECL 8'h04
`define AR_SUB_ACT 8'h08
`define AR_SUB_MODE 8'h0C
`define AR_OFF_CNT 8'h80
`define AR_CTRL_EN 0
`define AR_CTRL_USE_IN 1
`define AR_CTRL_GEN 2
`define AR_CTRL_CLR 3
`define AR_CTRL_NSHOT 4
`define AR_CTRL_RST 32'h0000_0015
`define AR_EVMASK_RST 16'hFFFF
`endif

// ---- design/ar_pkg.sv ----
// types shared by the auto-reclose sequencer and its users
package ar_pkg;
  typedef enum logic [3:0] {
    ST_READY, ST_START, ST_OPEN, ST_DEAD, ST_CLOSE, ST_RECLAIM,
    ST_GENRC, ST_FINAL, ST_LOCKED, ST_HALTED
  } ar_state_t;

  typedef struct packed {
    logic ready;
    logic running;
    logic dead;
    logic reclaim;
    logic arcing;
    logic gen_reclaim;
    logic final_trip;
    logic locked;
    logic halted;
    logic [4:0] shot;
    logic [4:0] req;
  } ar_status_t;

  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic level;
    logic [31:0] stamp;
  } ar_event_t;
endpackage : ar_pkg

// ---- design/breaker_auto_reclose_sequencer.sv ----
// auto-reclose sequencer: request arbitration, shot sequencing, events, counters
// What this block does
// - each shot holds one action mode bit: arcing or discrimination, never both.
// - request during reclaim advances to next shot, or final trip if none left.
// - arcing mode: request during reclaim runs arcing timer; reaching time advances.
// - request dropping pauses arcing timer; reclaim timer keeps running.
// - reclaim expiry means success: go to general reclaim or ready.
// - arcing time accumulates across activations within one reclaim period.
// - discrimination: request inside window halts sequencer, no more breaker commands.
// - after halt, refuse requests until manual reset and manual breaker close.
// - drive breaker open and close commands plus status indications.
// - log ON/OFF events with millisecond time stamps for commands and status.
// - cumulative counter per shot and per request source, clearable by command.
// - supervision failure on opening or closing forces the lock-out.
// - manual open during a sequence, or manual close outside dead time, resets the sequencer.
// - manual close during dead time enters general reclaim leading to lock-out.
// - settings act live, even in the middle of a sequence.
// - request, enable, reset, locking, critical and breaker position inputs raise an event on change; each source has a mask bit.
// - enable input counts only when its use bit is set.
// - manual reset input releases the locked state.
// - locking input forces locked; only manual reset returns to ready.
// - critical request locks immediately without any shot.
// - five request lines by fixed priority, line one highest.
// - follower breaker held open from the first open command until a successful reclaim or a return to ready.
// - follower breaker allowed to close after a successful reclaim.
// - a timer set to zero is skipped.
`timescale 1ns/100ps
`include "ar_params.svh"

module breaker_auto_reclose_sequencer #(
  parameter int TICK_DIV = `AR_TICK_CYC,
  parameter int TW = 20,
  parameter int CW = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic reclose_request_line_one,
  input wire logic reclose_request_line_two,
  input wire logic reclose_request_line_three,
  input wire logic reclose_request_line_four,
  input wire logic reclose_request_line_five,
  input wire logic sequencer_enable_input,
  input wire logic lock_release_input,
  input wire logic force_lock_input,
  input wire logic immediate_lock_request,
  input wire logic breaker_closed,
  input wire logic manual_open,
  input wire logic manual_close,
  input wire logic open_supervision_fail,
  input wire logic close_supervision_fail,
  output logic object_open_cmd,
  output logic object_close_cmd,
  output logic follower_open_cmd,
  output logic follower_close_permit,
  output ar_pkg::ar_status_t status,
  output ar_pkg::ar_event_t event_out
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [`AR_NSYNC-1:0] raw;
  logic [`AR_NSYNC-1:0] s1_q;
  logic [`AR_NSYNC-1:0] s2_q;
  logic [`AR_NSYNC-1:0] prev_q;
  logic [`AR_NSYNC-1:0] rise;

  assign raw = {close_supervision_fail, open_supervision_fail, manual_close, manual_open,
                breaker_closed, immediate_lock_request, force_lock_input, lock_release_input,
                sequencer_enable_input, reclose_request_line_five, reclose_request_line_four,
                reclose_request_line_three, reclose_request_line_two, reclose_request_line_one};

  genvar gi;
  generate
    for (gi = 0; gi < `AR_NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          prev_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  assign rise = s2_q & ~prev_q;

  logic [4:0] req_v;
  logic brk_closed;
  assign req_v = s2_q[4:0];
  assign brk_closed = s2_q[9];

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick and time stamp
  logic [31:0] div_q;
  logic tick_q;
  logic [31:0] stamp_q;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else if (div_q == 32'(TICK_DIV - 1))
    begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      stamp_q <= 32'h0000_0000;
    else if (tick_q)
      stamp_q <= stamp_q + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings registers
  logic en_q;
  logic use_in_q;
  logic gen_q;
  logic [2:0] nshot_q;
  logic clr_q;
  logic [15:0] evmask_q;
  logic [TW-1:0] start_set_q;
  logic [TW-1:0] genrc_set_q;
  logic [TW-1:0] dead_q [`AR_NSHOT];
  logic [TW-1:0] recl_q [`AR_NSHOT];
  logic [TW-1:0] act_q [`AR_NSHOT];
  logic [`AR_NSHOT-1:0] disc_q;
  logic [CW-1:0] cnt_q [2*`AR_NSHOT];
  logic [2*`AR_NSHOT-1:0] cnt_inc;
  localparam logic [31:0] CTRL_RST = `AR_CTRL_RST;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_q <= CTRL_RST[`AR_CTRL_EN];
      use_in_q <= CTRL_RST[`AR_CTRL_USE_IN];
      gen_q <= CTRL_RST[`AR_CTRL_GEN];
      nshot_q <= CTRL_RST[`AR_CTRL_NSHOT+:3];
      clr_q <= 1'b0;
      evmask_q <= `AR_EVMASK_RST;
      start_set_q <= '0;
      genrc_set_q <= '0;
    end
    else
    begin
      clr_q <= reg_wr && reg_addr == `AR_OFF_CTRL && reg_wdata[`AR_CTRL_CLR];
      if (reg_wr && reg_addr == `AR_OFF_CTRL)
      begin
        en_q <= reg_wdata[`AR_CTRL_EN];
        use_in_q <= reg_wdata[`AR_CTRL_USE_IN];
        gen_q <= reg_wdata[`AR_CTRL_GEN];
        nshot_q <= reg_wdata[`AR_CTRL_NSHOT+:3];
      end
      if (reg_wr && reg_addr == `AR_OFF_EVMASK)
        evmask_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `AR_OFF_START)
        start_set_q <= reg_wdata[TW-1:0];
      if (reg_wr && reg_addr == `AR_OFF_GENRC)
        genrc_set_q <= reg_wdata[TW-1:0];
    end
  end

  generate
    for (gi = 0; gi < `AR_NSHOT; gi++)
    begin : g_shot
      localparam logic [7:0] BASE = 8'(`AR_OFF_SHOT + gi * `AR_SHOT_STRIDE);
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          dead_q[gi] <= '0;
          recl_q[gi] <= '0;
          act_q[gi] <= '0;
          disc_q[gi] <= 1'b0;
        end
        else if (reg_wr)
        begin
          if (reg_addr == BASE + `AR_SUB_DEAD)
            dead_q[gi] <= reg_wdata[TW-1:0];
          if (reg_addr == BASE + `AR_SUB_RECL)
            recl_q[gi] <= reg_wdata[TW-1:0];
          if (reg_addr == BASE + `AR_SUB_ACT)
            act_q[gi] <= reg_wdata[TW-1:0];
          if (reg_addr == BASE + `AR_SUB_MODE)
            disc_q[gi] <= reg_wdata[0];
        end
      end
    end
    for (gi = 0; gi < 2 * `AR_NSHOT; gi++)
    begin : g_cnt
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          cnt_q[gi] <= '0;
        else if (cnt_inc[gi])
          cnt_q[gi] <= clr_q ? CW'(1) : cnt_q[gi] + CW'(1);
        else if (clr_q)
          cnt_q[gi] <= '0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // arbitration, timers and sequence state
  ar_pkg::ar_state_t state_q;
  ar_pkg::ar_state_t state_d;
  logic [2:0] shot_q;
  logic [2:0] shot_d;
  logic [2:0] src_q;
  logic [2:0] src_d;
  logic [2:0] win;
  logic req_any;
  logic en;
  logic [TW-1:0] tmr_q;
  logic [TW-1:0] arc_q;
  logic man_lock_q;
  logic halt_rel_q;
  logic seq;
  logic disc;
  logic [TW-1:0] act_now;

  function automatic logic done(input logic [TW-1:0] t, input logic [TW-1:0] set);
    done = (set == '0) || (t >= set);
  endfunction : done

  always_comb
  begin
    win = 3'h0;
    for (int i = `AR_NSHOT - 1; i >= 0; i--)
      if (req_v[i])
        win = 3'(i);
  end

  assign req_any = |req_v;
  assign en = en_q && (!use_in_q || s2_q[5]);
  assign seq = state_q inside {ar_pkg::ST_START, ar_pkg::ST_OPEN, ar_pkg::ST_DEAD,
                               ar_pkg::ST_CLOSE, ar_pkg::ST_RECLAIM};
  assign disc = disc_q[shot_q];
  assign act_now = act_q[shot_q];

  always_comb
  begin
    state_d = state_q;
    shot_d = shot_q;
    src_d = src_q;
    case (state_q)
      ar_pkg::ST_READY:
        if (en && req_any)
        begin
          state_d = ar_pkg::ST_START;
          src_d = win;
          shot_d = 3'h0;
        end
      ar_pkg::ST_START:
        if (!req_any)
          state_d = ar_pkg::ST_READY;
        else if (done(tmr_q, start_set_q))
          state_d = ar_pkg::ST_OPEN;
      ar_pkg::ST_OPEN:
        if (!brk_closed)
          state_d = ar_pkg::ST_DEAD;
      ar_pkg::ST_DEAD:
        if (done(tmr_q, dead_q[shot_q]))
          state_d = ar_pkg::ST_CLOSE;
      ar_pkg::ST_CLOSE:
        if (brk_closed)
          state_d = ar_pkg::ST_RECLAIM;
      ar_pkg::ST_RECLAIM:
        if (disc && req_any && !done(tmr_q, act_now))
          state_d = ar_pkg::ST_HALTED;
        else if (req_any && (disc || done(arc_q, act_now)))
        begin
          if (32'(shot_q) + 1 < 32'(nshot_q))
          begin
            state_d = ar_pkg::ST_OPEN;
            shot_d = shot_q + 3'h1;
          end
          else
            state_d = ar_pkg::ST_FINAL;
        end
        else if (done(tmr_q, recl_q[shot_q]))
          state_d = gen_q ? ar_pkg::ST_GENRC : ar_pkg::ST_READY;
      ar_pkg::ST_GENRC:
        if (req_any)
          state_d = ar_pkg::ST_FINAL;
        else if (done(tmr_q, genrc_set_q))
          state_d = man_lock_q ? ar_pkg::ST_LOCKED : ar_pkg::ST_READY;
      ar_pkg::ST_FINAL:
        if (!brk_closed)
          state_d = ar_pkg::ST_LOCKED;
      ar_pkg::ST_LOCKED:
        if (rise[6] && !s2_q[7])
          state_d = ar_pkg::ST_READY;
      ar_pkg::ST_HALTED:
        if (halt_rel_q && rise[11])
          state_d = ar_pkg::ST_READY;
      default:
        state_d = ar_pkg::ST_LOCKED;
    endcase
    if (seq && !en)
      state_d = ar_pkg::ST_READY;
    if (seq && (rise[10] || rise[11]))
      state_d = ar_pkg::ST_READY;
    if (state_q == ar_pkg::ST_DEAD && rise[11])
      state_d = ar_pkg::ST_GENRC;
    if (rise[12] && state_q inside {ar_pkg::ST_OPEN, ar_pkg::ST_FINAL})
      state_d = ar_pkg::ST_LOCKED;
    if (rise[13] && state_q == ar_pkg::ST_CLOSE)
      state_d = ar_pkg::ST_LOCKED;
    if (s2_q[7])
      state_d = ar_pkg::ST_LOCKED;
    if (s2_q[8])
      state_d = ar_pkg::ST_LOCKED;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ar_pkg::ST_READY;
      shot_q <= 3'h0;
      src_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      shot_q <= shot_d;
      src_q <= src_d;
    end
  end

  // sequence timer restarts on every state or shot change
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      tmr_q <= '0;
    else if (state_d != state_q || shot_d != shot_q)
      tmr_q <= '0;
    else if (tick_q && tmr_q != '1)
      tmr_q <= tmr_q + TW'(1);
  end

  // arcing total clears only when a reclaim period begins
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      arc_q <= '0;
    else if (state_d == ar_pkg::ST_RECLAIM && state_q != ar_pkg::ST_RECLAIM)
      arc_q <= '0;
    else if (state_q == ar_pkg::ST_RECLAIM && !disc && req_any && tick_q && arc_q != '1)
      arc_q <= arc_q + TW'(1);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      man_lock_q <= 1'b0;
      halt_rel_q <= 1'b0;
    end
    else
    begin
      if (state_q == ar_pkg::ST_DEAD && state_d == ar_pkg::ST_GENRC)
        man_lock_q <= 1'b1;
      else if (state_d != ar_pkg::ST_GENRC)
        man_lock_q <= 1'b0;
      if (state_q != ar_pkg::ST_HALTED)
        halt_rel_q <= 1'b0;
      else if (rise[6])
        halt_rel_q <= 1'b1;
    end
  end

  always_comb
  begin
    cnt_inc = '0;
    if (state_q == ar_pkg::ST_DEAD && state_d == ar_pkg::ST_CLOSE)
      cnt_inc[shot_q] = 1'b1;
    if (state_q == ar_pkg::ST_START && state_d == ar_pkg::ST_OPEN)
      cnt_inc[`AR_NSHOT + 32'(src_q)] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // commands, follower link and status
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      object_open_cmd <= 1'b0;
      object_close_cmd <= 1'b0;
      follower_open_cmd <= 1'b0;
      follower_close_permit <= 1'b0;
      status <= '0;
    end
    else
    begin
      object_open_cmd <= state_d inside {ar_pkg::ST_OPEN, ar_pkg::ST_FINAL};
      object_close_cmd <= state_d == ar_pkg::ST_CLOSE;
      if (state_q == ar_pkg::ST_START && state_d == ar_pkg::ST_OPEN)
      begin
        follower_open_cmd <= 1'b1;
        follower_close_permit <= 1'b0;
      end
      else if (state_q == ar_pkg::ST_RECLAIM &&
               state_d inside {ar_pkg::ST_GENRC, ar_pkg::ST_READY})
      begin
        follower_open_cmd <= 1'b0;
        follower_close_permit <= 1'b1;
      end
      else if (state_d == ar_pkg::ST_READY)
        follower_open_cmd <= 1'b0;
      status.ready <= state_d == ar_pkg::ST_READY && en;
      status.running <= state_d inside {ar_pkg::ST_OPEN, ar_pkg::ST_DEAD,
                                        ar_pkg::ST_CLOSE, ar_pkg::ST_RECLAIM};
      status.dead <= state_d == ar_pkg::ST_DEAD;
      status.reclaim <= state_d == ar_pkg::ST_RECLAIM;
      status.arcing <= state_d == ar_pkg::ST_RECLAIM && !disc && req_any;
      status.gen_reclaim <= state_d == ar_pkg::ST_GENRC;
      status.final_trip <= state_d == ar_pkg::ST_FINAL;
      status.locked <= state_d == ar_pkg::ST_LOCKED;
      status.halted <= state_d == ar_pkg::ST_HALTED;
      status.shot <= (state_d inside {ar_pkg::ST_START, ar_pkg::ST_OPEN, ar_pkg::ST_DEAD,
                      ar_pkg::ST_CLOSE, ar_pkg::ST_RECLAIM}) ? 5'(5'h01 << shot_d) : 5'h00;
      status.req <= (state_d inside {ar_pkg::ST_START, ar_pkg::ST_OPEN, ar_pkg::ST_DEAD,
                     ar_pkg::ST_CLOSE, ar_pkg::ST_RECLAIM}) ? 5'(5'h01 << src_d) : 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event recorder: one pending flag per source, lowest index first
  logic [`AR_NEV-1:0] ev_now;
  logic [`AR_NEV-1:0] ev_prev_q;
  logic [`AR_NEV-1:0] pend_q;
  logic [`AR_NEV-1:0] grant;
  logic [3:0] ev_idx;

  assign ev_now = {brk_closed, s2_q[8:5], req_v, status.final_trip, status.halted,
                   status.locked, status.running, object_close_cmd, object_open_cmd};

  always_comb
  begin
    ev_idx = 4'h0;
    for (int i = `AR_NEV - 1; i >= 0; i--)
      if (pend_q[i])
        ev_idx = 4'(i);
    grant = (|pend_q) ? `AR_NEV'(1) << ev_idx : '0;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ev_prev_q <= '0;
      pend_q <= '0;
      event_out <= '0;
    end
    else
    begin
      ev_prev_q <= ev_now;
      pend_q <= (pend_q & ~grant) | ((ev_now ^ ev_prev_q) & evmask_q);
      event_out.valid <= |pend_q;
      event_out.src <= ev_idx;
      event_out.level <= ev_now[ev_idx];
      event_out.stamp <= stamp_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port
  logic [31:0] rd_d;
  logic [7:0] rel;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    rel = reg_addr - `AR_OFF_SHOT;
    if (reg_addr == `AR_OFF_CTRL)
      rd_d = {25'h0, nshot_q, 1'b0, gen_q, use_in_q, en_q};
    else if (reg_addr == `AR_OFF_STATUS)
      rd_d = {9'h0, src_q, shot_q, 1'b0, state_q, 12'(status[18:9])};
    else if (reg_addr == `AR_OFF_EVMASK)
      rd_d = {16'h0, evmask_q};
    else if (reg_addr == `AR_OFF_START)
      rd_d = 32'(start_set_q);
    else if (reg_addr == `AR_OFF_GENRC)
      rd_d = 32'(genrc_set_q);
    else if (reg_addr == `AR_OFF_STAMP)
      rd_d = stamp_q;
    else if (reg_addr >= `AR_OFF_SHOT && rel < 8'(`AR_NSHOT * `AR_SHOT_STRIDE))
    begin
      case (rel[3:0])
        4'h0: rd_d = 32'(dead_q[rel[6:4]]);
        4'h4: rd_d = 32'(recl_q[rel[6:4]]);
        4'h8: rd_d = 32'(act_q[rel[6:4]]);
        4'hC: rd_d = {31'h0, disc_q[rel[6:4]]};
        default: rd_d = 32'h0000_0000;
      endcase
    end
    else if (reg_addr >= `AR_OFF_CNT && reg_addr[1:0] == 2'h0 &&
             reg_addr < 8'(`AR_OFF_CNT + 8 * `AR_NSHOT))
      rd_d = 32'(cnt_q[reg_addr[5:2]]);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rd_d;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule : breaker_auto_reclose_sequencer

// ---- tb/breaker_auto_reclose_sequencer_asserts.sv ----
// port checks for the auto-reclose sequencer
`timescale 1ns/100ps
module breaker_auto_reclose_sequencer_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic force_lock_input,
  input wire logic immediate_lock_request,
  input wire logic object_open_cmd,
  input wire logic object_close_cmd,
  input wire logic follower_open_cmd,
  input wire logic follower_close_permit,
  input wire ar_pkg::ar_status_t status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  cmd_exclusive_a: assert property (!(object_open_cmd && object_close_cmd))
    else $error("open and close commands together");
  halt_silent_a: assert property (status.halted |-> !object_open_cmd && !object_close_cmd)
    else $error("breaker command while halted");
  lock_no_close_a: assert property (status.locked |-> !object_close_cmd)
    else $error("close command while locked");
  dead_no_close_a: assert property (status.dead |-> !object_close_cmd)
    else $error("close command during dead time");
  shot_onehot_a: assert property ($onehot0(status.shot))
    else $error("more than one shot running");
  req_onehot_a: assert property ($onehot0(status.req))
    else $error("more than one request source shown");
  critical_lock_a: assert property (immediate_lock_request [*8] |-> status.locked)
    else $error("critical request did not lock");
  force_lock_a: assert property (force_lock_input [*8] |-> status.locked && !status.ready)
    else $error("locking input did not hold locked");
  follower_excl_a: assert property (follower_close_permit |-> !follower_open_cmd)
    else $error("follower permit while held open");
endmodule : breaker_auto_reclose_sequencer_asserts

bind breaker_auto_reclose_sequencer breaker_auto_reclose_sequencer_asserts i_chk (
  .mclk, .rst_b, .force_lock_input, .immediate_lock_request, .object_open_cmd,
  .object_close_cmd, .follower_open_cmd, .follower_close_permit, .status);

// ---- tb/breaker_model.sv ----
// breaker with its object control supervision
`timescale 1ns/100ps
module breaker_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic hand_close,
  input wire logic fail_close,
  output logic breaker_closed,
  output logic close_fail
);
  logic [3:0] cnt_q;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      breaker_closed <= 1'b1;
      cnt_q <= 4'h0;
      close_fail <= 1'b0;
    end
    else
    begin
      cnt_q <= (open_cmd || close_cmd) ? cnt_q + 4'h1 : 4'h0;
      close_fail <= fail_close && close_cmd;
      if (hand_close)
        breaker_closed <= 1'b1;
      else if (open_cmd && cnt_q == 4'h3)
        breaker_closed <= 1'b0;
      else if (close_cmd && !fail_close && cnt_q == 4'h3)
        breaker_closed <= 1'b1;
    end
  end
endmodule : breaker_model

// ---- tb/tb.sv ----
// self-checking bench for the auto-reclose sequencer
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] req = 5'h00;
  logic [4:0] ctl = 5'h00;
  logic en_in = 1'b0;
  logic fail_cl = 1'b0;
  logic [31:0] reg_rdata;
  logic brk, cl_fail, open_cmd, close_cmd, f_open, f_permit;
  ar_pkg::ar_status_t status;
  ar_pkg::ar_event_t ev;
  logic [15:0] ev_seen = 16'h0;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  always #10 mclk = ~mclk;

  breaker_auto_reclose_sequencer #(.TICK_DIV(4)) i_dut (
    .mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reclose_request_line_one(req[0]), .reclose_request_line_two(req[1]),
    .reclose_request_line_three(req[2]), .reclose_request_line_four(req[3]),
    .reclose_request_line_five(req[4]), .sequencer_enable_input(en_in),
    .lock_release_input(ctl[0]), .force_lock_input(ctl[1]),
    .immediate_lock_request(ctl[2]), .breaker_closed(brk), .manual_open(ctl[4]),
    .manual_close(ctl[3]), .open_supervision_fail(1'b0), .close_supervision_fail(cl_fail),
    .object_open_cmd(open_cmd), .object_close_cmd(close_cmd), .follower_open_cmd(f_open),
    .follower_close_permit(f_permit), .status, .event_out(ev));

  breaker_model i_brk (.mclk, .rst_b, .open_cmd, .close_cmd, .hand_close(ctl[3]),
    .fail_close(fail_cl), .breaker_closed(brk), .close_fail(cl_fail));

  always @(posedge mclk)
    if (ev.valid === 1'b1)
      ev_seen[ev.src] <= 1'b1;

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      results();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rdata, e);
  endtask : rd

  task automatic pulse(input int i);
    ctl[i] <= 1'b1;
    repeat (12) @(posedge mclk);
    ctl[i] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : pulse

  task automatic shot_in(input int l);
    req[l] <= 1'b1;
    wait (brk === 1'b0);
    req <= 5'h00;
    wait (status.reclaim === 1'b1);
  endtask : shot_in

  task automatic shot_cfg(input logic [7:0] b, input logic [31:0] d);
    wr(b, d);
    wr(b + 8'h04, 32'h28);
    wr(b + 8'h08, 32'h6);
  endtask : shot_cfg

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(8'h00, 32'h15);
    rd(8'h08, 32'hFFFF);
    rd(8'h2C, 32'h0);
    wr(8'h7C, 32'hFFFFFFFF);
    rd(8'h7C, 32'h0);
    rd(8'h84, 32'h0);
  endtask : t_regs

  task automatic t_success;
    wr(8'h00, 32'h23);
    req[2] <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(open_cmd, 1'b0);
    req[2] <= 1'b0;
    en_in <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(status.ready, 1'b1);
    en_in <= 1'b0;
    wr(8'h00, 32'h21);
    req[1] <= 1'b1;
    shot_in(0);
    chk(f_open, 1'b1);
    wait (status.ready === 1'b1);
    repeat (2) @(posedge mclk);
    chk(f_permit, 1'b1);
    chk(f_open, 1'b0);
    rd(8'h80, 32'h1);
    rd(8'h94, 32'h1);
    rd(8'h98, 32'h0);
    wr(8'h00, 32'h29);
    rd(8'h94, 32'h0);
  endtask : t_success

  task automatic t_arc;
    shot_in(0);
    req[3] <= 1'b1;
    repeat (16) @(posedge mclk);
    req[3] <= 1'b0;
    repeat (40) @(posedge mclk);
    chk(open_cmd, 1'b0);
    chk(status.reclaim, 1'b1);
    req[3] <= 1'b1;
    n = 0;
    while (open_cmd !== 1'b1)
    begin
      @(posedge mclk);
      n++;
    end
    chk(n < 20, 1'b1);
    wait (brk === 1'b0);
    req <= 5'h00;
    wait (status.reclaim === 1'b1);
    req[3] <= 1'b1;
    wait (status.final_trip === 1'b1);
    chk(open_cmd, 1'b1);
    wait (status.locked === 1'b1);
    req <= 5'h00;
    pulse(0);
    wait (status.ready === 1'b1);
    chk(status.locked, 1'b0);
    pulse(3);
  endtask : t_arc

  task automatic t_discrim;
    shot_in(0);
    wr(8'h2C, 32'h1);
    req[4] <= 1'b1;
    wait (status.halted === 1'b1);
    repeat (30) @(posedge mclk);
    chk(open_cmd, 1'b0);
    pulse(0);
    chk(status.halted, 1'b1);
    req <= 5'h00;
    pulse(3);
    wait (status.ready === 1'b1);
    rd(8'h2C, 32'h1);
    wr(8'h2C, 32'h0);
  endtask : t_discrim

  task automatic t_lock;
    ev_seen <= 16'h0;
    ctl[1] <= 1'b1;
    repeat (12) @(posedge mclk);
    pulse(0);
    chk(status.locked, 1'b1);
    ctl[1] <= 1'b0;
    pulse(0);
    chk(status.ready, 1'b1);
    chk(ev_seen[13], 1'b1);
    wr(8'h08, 32'h0);
    ev_seen <= 16'h0;
    pulse(2);
    chk(status.locked, 1'b1);
    pulse(0);
    wait (status.ready === 1'b1);
    chk(ev_seen[14], 1'b0);
    wr(8'h08, 32'hFFFF);
  endtask : t_lock

  task automatic t_dead_close;
    req[0] <= 1'b1;
    wait (status.dead === 1'b1);
    req <= 5'h00;
    pulse(4);
    chk(status.ready, 1'b1);
    pulse(3);
    req[0] <= 1'b1;
    wait (status.dead === 1'b1);
    req <= 5'h00;
    pulse(3);
    chk(status.gen_reclaim, 1'b1);
    wait (status.locked === 1'b1);
    pulse(0);
    wait (status.ready === 1'b1);
  endtask : t_dead_close

  task automatic t_superv;
    fail_cl <= 1'b1;
    req[0] <= 1'b1;
    wait (brk === 1'b0);
    req <= 5'h00;
    wait (status.locked === 1'b1);
    chk(close_cmd, 1'b0);
    fail_cl <= 1'b0;
    pulse(0);
    pulse(3);
    chk(status.ready, 1'b1);
  endtask : t_superv

  task automatic results;
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    shot_cfg(8'h20, 32'hA);
    shot_cfg(8'h30, 32'h2);
    wr(8'h10, 32'hA);
    wr(8'h00, 32'h21);
    t_success();
    t_arc();
    t_discrim();
    t_lock();
    t_dead_close();
    t_superv();
    results();
  end
endmodule : tb
